// file: logic/fxa_decoder.sv
/*
  Command decoder of a serial NOR flash: chooses three- or four-byte
  addressing, applies the bank-select byte and tracks the streaming address.
  Assumes SPI pins from the host in single-line mode, sampled by clk, and an
  AXI4-Lite master reaching the registers.
*/
`timescale 1ns/1ps
module fxa_decoder #(
  parameter logic [7:0] ENTER_WIDE_OPCODE = 8'hA5,
  parameter int ARRAY_BYTES = 32'h0200_0000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // SPI pins from the host
  input wire logic spiCsN,
  input wire logic spiSck,
  input wire logic spiSi,
  // AXI4-Lite write address and data
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Decoded command
  output fxa_pkg::fxa_cmd_s cmd
);
  import fxa_pkg::*;

  // Refuse array sizes the wrapping address counter cannot serve
  if (ARRAY_BYTES < 2 || ARRAY_BYTES > 32'h0200_0000)
  begin : g_bad_size
    $error("ARRAY_BYTES out of range");
  end

  // Last array byte; the stream wraps to zero past it
  localparam logic [31:0] LAST_ADDR = 32'(ARRAY_BYTES - 1);

  // Opcode classification
  function automatic fxa_cls_e classify(input logic [7:0] op);
    fxa_cls_e c;
    c = CLS_NONE;
    case (op)
      8'h13, 8'h0C, 8'hBC, 8'h3C, 8'hEC, 8'h6C, 8'h0E, 8'hBE, 8'hEE,
      8'h12, 8'h34, 8'h3E, 8'h21, 8'h5C, 8'hDC,
      8'h25, 8'hE0, 8'hE1, 8'hE2, 8'hE3:
        c = CLS_FIXED_WIDE;
      8'h03, 8'h0B, 8'hBB, 8'h3B, 8'hEB, 8'h6B, 8'h0D, 8'hBD, 8'hED,
      8'h02, 8'h32, 8'h38, 8'hD7, 8'h20, 8'h52, 8'hD8,
      8'h26, 8'hFA, 8'hFB, 8'hFC, 8'hFD:
        c = CLS_SWITCHABLE;
      default:
        c = (op == ENTER_WIDE_OPCODE) ? CLS_ENTER_WIDE : CLS_NONE;
    endcase
    return c;
  endfunction : classify

  // Enter opcode must not shadow a listed address opcode
  if (classify(ENTER_WIDE_OPCODE) != CLS_ENTER_WIDE)
  begin : g_bad_enter
    $error("ENTER_WIDE_OPCODE collides with an address opcode");
  end

  // Array address from received address and bank
  function automatic logic [31:0] formStart(input logic [31:0] a, input logic isWide, input logic [7:0] bank);
    logic [31:0] r;
    r = a;
    if (!isWide)
    begin
      r = {7'h00, bank[BANK_BIT], a[23:0]};
    end
    return r;
  endfunction : formStart

  typedef struct packed {
    logic [2:0] csSync;
    logic [2:0] sckSync;
    logic [2:0] siSync;
    logic csStab;
    logic sckStab;
    logic siStab;
    fxa_state_e state;
    logic [6:0] shift;
    logic [2:0] bitCnt;
    logic [2:0] byteCnt;
    logic [2:0] addrLen;
    logic [7:0] opcode;
    logic [31:0] addr;
    logic wideMode;
    logic [7:0] bank;
    fxa_cmd_s cmd;
    logic awHave;
    logic [3:0] awAddr;
    logic wHave;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
  } fxa_regs_s;

  fxa_regs_s r_q;
  fxa_regs_s r_d;

  // Byte completing on the current serial clock edge
  logic [7:0] rxByte;
  logic sckRise;
  logic csNext;
  logic sckNext;
  logic siNext;
  logic four_byte_address_enable;
  logic [2:0] lenSel;
  logic [31:0] addrNext;
  // Enter command seen this cycle; wins over a status clear
  logic wideSet;

  assign s_axi_awready = !r_q.awHave && !r_q.bValid;
  assign s_axi_wready = !r_q.wHave && !r_q.bValid;
  assign s_axi_arready = !r_q.rValid;
  assign s_axi_bvalid = r_q.bValid;
  assign s_axi_bresp = r_q.bResp;
  assign s_axi_rvalid = r_q.rValid;
  assign s_axi_rdata = r_q.rData;
  assign s_axi_rresp = r_q.rResp;
  assign cmd = r_q.cmd;

  // Next-state logic
  always_comb
  begin
    r_d = r_q;
    r_d.cmd.valid = 1'b0;
    r_d.cmd.byteStrobe = 1'b0;
    // Three-stage pin synchronisers, stable once stages two and three agree
    r_d.csSync = {r_q.csSync[1:0], spiCsN};
    r_d.sckSync = {r_q.sckSync[1:0], spiSck};
    r_d.siSync = {r_q.siSync[1:0], spiSi};
    csNext = (r_q.csSync[2] == r_q.csSync[1]) ? r_q.csSync[2] : r_q.csStab;
    sckNext = (r_q.sckSync[2] == r_q.sckSync[1]) ? r_q.sckSync[2] : r_q.sckStab;
    siNext = (r_q.siSync[2] == r_q.siSync[1]) ? r_q.siSync[2] : r_q.siStab;
    r_d.csStab = csNext;
    r_d.sckStab = sckNext;
    r_d.siStab = siNext;
    sckRise = sckNext && !r_q.sckStab;
    rxByte = {r_q.shift, siNext};
    four_byte_address_enable = r_q.bank[EXT_ADDR_BIT];
    lenSel = ADDR_BYTES_NARROW;
    addrNext = {r_q.addr[23:0], rxByte};
    wideSet = 1'b0;

    // Serial frame handling
    if (csNext)
    begin
      r_d.state = ST_IDLE;
    end
    else if (r_q.state == ST_IDLE)
    begin
      r_d.state = ST_OPCODE;
      r_d.bitCnt = 3'h0;
      r_d.byteCnt = 3'h0;
      r_d.addr = 32'h0000_0000;
    end
    else if (sckRise)
    begin
      r_d.shift = rxByte[6:0];
      r_d.bitCnt = r_q.bitCnt + 3'h1;
      if (r_q.bitCnt == 3'h7)
      begin
        case (r_q.state)
          ST_OPCODE:
          begin
            r_d.opcode = rxByte;
            case (classify(rxByte))
              CLS_FIXED_WIDE:
              begin
                r_d.addrLen = ADDR_BYTES_WIDE;
                r_d.state = ST_ADDR;
              end
              CLS_SWITCHABLE:
              begin
                if (four_byte_address_enable || r_q.wideMode)
                begin
                  lenSel = ADDR_BYTES_WIDE;
                end
                r_d.addrLen = lenSel;
                r_d.state = ST_ADDR;
              end
              CLS_ENTER_WIDE:
              begin
                if (!four_byte_address_enable)
                begin
                  r_d.wideMode = 1'b1;
                  wideSet = 1'b1;
                end
                r_d.state = ST_IGNORE;
              end
              default:
                r_d.state = ST_IGNORE;
            endcase
          end
          ST_ADDR:
          begin
            r_d.addr = addrNext;
            r_d.byteCnt = r_q.byteCnt + 3'h1;
            if (r_q.byteCnt + 3'h1 == r_q.addrLen)
            begin
              r_d.cmd.valid = 1'b1;
              r_d.cmd.opcode = r_q.opcode;
              r_d.cmd.wide = (r_q.addrLen == ADDR_BYTES_WIDE);
              r_d.cmd.startAddr = formStart(addrNext, r_q.addrLen == ADDR_BYTES_WIDE, r_q.bank);
              r_d.cmd.curAddr = r_d.cmd.startAddr;
              r_d.state = ST_DATA;
            end
          end
          ST_DATA:
          begin
            // Counter runs on through bank edges, bank byte untouched
            r_d.cmd.byteStrobe = 1'b1;
            if (r_q.cmd.curAddr >= LAST_ADDR)
            begin
              r_d.cmd.curAddr = 32'h0000_0000;
            end
            else
            begin
              r_d.cmd.curAddr = r_q.cmd.curAddr + 32'h0000_0001;
            end
          end
          default:
            r_d.state = r_q.state;
        endcase
      end
    end

    // Bus write channels
    if (s_axi_awvalid && !r_q.awHave && !r_q.bValid)
    begin
      r_d.awHave = 1'b1;
      r_d.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !r_q.wHave && !r_q.bValid)
    begin
      r_d.wHave = 1'b1;
      r_d.wData = s_axi_wdata;
      r_d.wStrb = s_axi_wstrb;
    end
    if (r_q.awHave && r_q.wHave)
    begin
      r_d.awHave = 1'b0;
      r_d.wHave = 1'b0;
      r_d.bValid = 1'b1;
      r_d.bResp = RESP_SLVERR;
      case (r_q.awAddr)
        BANK_SEL_OFS:
        begin
          if (r_q.wStrb[0])
          begin
            r_d.bank = r_q.wData[7:0];
          end
          r_d.bResp = RESP_OKAY;
        end
        STATUS_OFS:
        begin
          // Writing a zero to bit 0 leaves four-byte mode
          if (r_q.wStrb[0] && !r_q.wData[0] && !wideSet)
          begin
            r_d.wideMode = 1'b0;
          end
          r_d.bResp = RESP_OKAY;
        end
        START_ADDR_OFS, CUR_ADDR_OFS:
          r_d.bResp = RESP_OKAY;
        default:
          r_d.bResp = RESP_SLVERR;
      endcase
    end
    if (r_q.bValid && s_axi_bready)
    begin
      r_d.bValid = 1'b0;
    end

    // Bus read channel
    if (s_axi_arvalid && !r_q.rValid)
    begin
      r_d.rValid = 1'b1;
      r_d.rResp = RESP_OKAY;
      case (s_axi_araddr)
        BANK_SEL_OFS:
          r_d.rData = {24'h00_0000, r_q.bank};
        // Status: last decoded opcode, data phase, effective width, mode
        STATUS_OFS:
          r_d.rData = {16'h0000, r_q.cmd.opcode, 5'h00, r_q.state == ST_DATA, four_byte_address_enable || r_q.wideMode,
                       r_q.wideMode};
        START_ADDR_OFS:
          r_d.rData = r_q.cmd.startAddr;
        CUR_ADDR_OFS:
          r_d.rData = r_q.cmd.curAddr;
        default:
        begin
          r_d.rData = 32'h0000_0000;
          r_d.rResp = RESP_SLVERR;
        end
      endcase
    end
    else if (r_q.rValid && s_axi_rready)
    begin
      r_d.rValid = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      r_q <= '0;
      r_q.csSync <= 3'h7;
      r_q.csStab <= 1'b1;
      r_q.state <= ST_IDLE;
      r_q.bank <= BANK_SEL_RST;
      r_q.addrLen <= ADDR_BYTES_NARROW;
    end
    else
    begin
      r_q <= r_d;
    end
  end

endmodule : fxa_decoder

// file: pkg/fxa_pkg.sv
/*
  Constants, types and register map of the flash extended-addressing decoder.
  Assumes a single 250 MHz system clock and SPI pins sampled from outside it.
*/
// Function
// - dedicated four-byte opcodes always take four address bytes
// - extended-address bit 7 set makes switchable opcodes take four bytes
// - enter-four-byte command switches width only while bit 7 is clear
// - three-byte address is an offset inside the selected 16-Mbyte bank
// - bank-select supplies the top address byte in three-byte mode; the code takes only its bit 0, as address bit 24, upper bits zero
// - bank extension applies to reads, erases and programs alike
// - bank-select is volatile and resets to bank 0
// - reads stream across bank boundaries with no extra delay
// - a read crossing a bank leaves bank-select unchanged
// - bank-select forms only the start address; later bytes follow counter
// - bank bit 0 picks bank 0 or 01000000h to 01FFFFFFh
// - decode 13h normal read and 0Ch fast read as four-byte
// - decode BCh dual I/O and 3Ch dual output reads as four-byte
// - decode ECh quad I/O and 6Ch quad output reads as four-byte
// - decode 0Eh, BEh, EEh double-rate reads as four-byte
// - decode 12h page program and 34h or 3Eh quad program as four-byte
// - decode 21h, 5Ch, DCh erases as four-byte
// - decode 25h and E0h to E3h protection opcodes as four-byte
// - standard reads take three or four bytes per extended-address bit
// - 02h, 32h, 38h programs take width per extended-address bit
// - D7h, 20h, 52h, D8h, 26h, FAh to FDh take width per that bit
package fxa_pkg;

  // Register byte offsets
  localparam logic [3:0] BANK_SEL_OFS = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h4;
  localparam logic [3:0] START_ADDR_OFS = 4'h8;
  localparam logic [3:0] CUR_ADDR_OFS = 4'hC;

  // Bank-select fields and reset value
  localparam int EXT_ADDR_BIT = 7;
  localparam int BANK_BIT = 0;
  localparam logic [7:0] BANK_SEL_RST = 8'h00;

  // Address byte counts
  localparam logic [2:0] ADDR_BYTES_NARROW = 3'h3;
  localparam logic [2:0] ADDR_BYTES_WIDE = 3'h4;

  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Command classes from the opcode decoder
  typedef enum logic [1:0] {
    CLS_NONE = 2'b00,
    CLS_FIXED_WIDE = 2'b01,
    CLS_SWITCHABLE = 2'b10,
    CLS_ENTER_WIDE = 2'b11
  } fxa_cls_e;

  // Frame states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_OPCODE = 3'b001,
    ST_ADDR = 3'b010,
    ST_DATA = 3'b011,
    ST_IGNORE = 3'b100
  } fxa_state_e;

  // Decoded command towards the array
  typedef struct packed {
    logic valid;
    logic [7:0] opcode;
    logic wide;
    logic [31:0] startAddr;
    logic byteStrobe;
    logic [31:0] curAddr;
  } fxa_cmd_s;

endpackage : fxa_pkg

// file: test/flash_extended_addressing_tb.sv
/*
  Self-checking bench of the extended-addressing decoder with a host model.
  Assumes the default enter-wide opcode and a 32-Mbyte array.
*/
`timescale 1ns/1ps
module flash_extended_addressing_tb;
  import fxa_pkg::*;
  localparam logic [7:0] ENTER = 8'hA5;
  localparam int ARRAY = 32'h0200_0000;
  logic [7:0] fixOp [20] = '{8'h13, 8'h0C, 8'hBC, 8'h3C, 8'hEC, 8'h6C, 8'h0E, 8'hBE, 8'hEE, 8'h12,
    8'h34, 8'h3E, 8'h21, 8'h5C, 8'hDC, 8'h25, 8'hE0, 8'hE1, 8'hE2, 8'hE3};
  logic [7:0] swOp [21] = '{8'h03, 8'h0B, 8'hBB, 8'h3B, 8'hEB, 8'h6B, 8'h0D, 8'hBD, 8'hED, 8'h02,
    8'h32, 8'h38, 8'hD7, 8'h20, 8'h52, 8'hD8, 8'h26, 8'hFA, 8'hFB, 8'hFC, 8'hFD};
  logic clk = 1'b0, sys_rst = 1'b1, spiCsN, spiSck, spiSi;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, sa;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, wd;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [7:0] bankReg = 8'h00;
  logic entered = 1'b0;
  logic [7:0] lastOp = 8'h00;
  fxa_cmd_s cmd;
  int errors = 0, tests_run = 0, cyc = 0, nv, ns;

  fxa_host host (.spiCsN, .spiSck, .spiSi);
  fxa_decoder #(.ENTER_WIDE_OPCODE(ENTER), .ARRAY_BYTES(ARRAY)) uut (.clk, .sys_rst, .spiCsN, .spiSck,
    .spiSi, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cmd);

  // Clock
  initial
  begin
    forever #2 clk = ~clk;
  end

  // Capture of command pulses where outputs are settled
  always @(negedge clk)
  begin
    if (cmd.valid === 1'b1)
    begin
      nv++;
      sa = cmd.startAddr;
      wd = cmd.wide;
    end
    if (cmd.byteStrobe === 1'b1)
      ns++;
  end

  // Hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 100000)
    begin
      errors++;
      results();
    end
  end

  task automatic results();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // One bus transfer; ready sampled mid-cycle, released after the taking edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
    output logic [1:0] rs, output logic [31:0] rd);
    logic [2:0] p, h;
    @(posedge clk);
    p = w ? 3'b111 : 3'b101;
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_bready <= w;
    s_axi_arvalid <= !w;
    s_axi_rready <= !w;
    while (p != 3'b000)
    begin
      @(negedge clk);
      h = p & (w ? {s_axi_awready, s_axi_wready, s_axi_bvalid} : {s_axi_arready, 1'b0, s_axi_rvalid});
      if (h[0])
        {rs, rd} = {w ? s_axi_bresp : s_axi_rresp, s_axi_rdata};
      @(posedge clk);
      p = p & ~h;
      if (h[2])
        {s_axi_awvalid, s_axi_arvalid} <= 2'b00;
      if (h[1])
        s_axi_wvalid <= 1'b0;
      if (h[0])
        {s_axi_bready, s_axi_rready} <= 2'b00;
    end
  endtask : bus

  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    logic [1:0] rs;
    logic [31:0] rd;
    bus(1'b1, a, d, rs, rd);
    chk("write resp", RESP_OKAY, rs);
    if (a == BANK_SEL_OFS)
      bankReg = d[7:0];
    if (a == STATUS_OFS && !d[0])
      entered = 1'b0;
  endtask : wreg

  task automatic rreg(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] er);
    logic [1:0] rs;
    logic [31:0] rd;
    bus(1'b0, a, 32'h0, rs, rd);
    chk("read resp", er, rs);
    chk("read data", e, rd & m);
  endtask : rreg

  // Address width the reference model expects for an opcode
  function automatic int width(input logic [7:0] op);
    if (op inside {fixOp})
      return 4;
    if (op inside {swOp})
      return (bankReg[7] | entered) ? 4 : 3;
    return 0;
  endfunction : width

  // Send one frame and compare the decoded command with the model
  task automatic run(input logic [7:0] op, input int nd, input logic [31:0] ad);
    int na;
    logic [31:0] e;
    logic [31:0] c;
    na = width(op);
    e = (na == 4) ? ad : {7'h00, bankReg[0], ad[23:0]};
    nv = 0;
    ns = 0;
    @(posedge clk);
    host.frame(op, ad, na, nd);
    if (op == ENTER && !bankReg[7])
      entered = 1'b1;
    chk("valid count", na > 0, nv);
    chk("strobes", nd, ns);
    if (na > 0)
    begin
      chk("wide", na == 4, wd);
      chk("start", e, sa);
      lastOp = op;
      c = e;
      repeat (nd)
        c = (c >= ARRAY - 1) ? 32'h0 : c + 32'h1;
      chk("opcode", op, cmd.opcode);
      chk("current", c, cmd.curAddr);
    end
  endtask : run

  // Main sequence
  initial
  begin
    void'($urandom(32'h9B7D));
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (6) @(posedge clk);
    rreg(BANK_SEL_OFS, 32'hFF, {24'h0, BANK_SEL_RST}, RESP_OKAY);
    rreg(4'h2, 32'hFFFF_FFFF, 32'h0, RESP_SLVERR);
    wreg(BANK_SEL_OFS, 32'h01);
    foreach (fixOp[i])
      run(fixOp[i], 0, $urandom);
    foreach (swOp[i])
    begin
      wreg(BANK_SEL_OFS, {24'h0, i[0], 6'h00, 1'($urandom)});
      run(swOp[i], 0, $urandom);
    end
    wreg(BANK_SEL_OFS, 32'h80);
    run(ENTER, 0, 32'h0);
    rreg(STATUS_OFS, 32'hFF03, {16'h0, lastOp, 8'h02}, RESP_OKAY);
    wreg(BANK_SEL_OFS, 32'h00);
    run(ENTER, 0, 32'h0);
    run(8'h02, 1, $urandom);
    wreg(STATUS_OFS, 32'h0);
    run(8'h03, 1, $urandom);
    wreg(BANK_SEL_OFS, 32'h01);
    run(8'h03, 3, 32'h00FF_FFFE);
    wreg(BANK_SEL_OFS, 32'h00);
    run(8'h0B, 3, 32'h00FF_FFFE);
    rreg(BANK_SEL_OFS, 32'hFF, 32'h0, RESP_OKAY);
    rreg(START_ADDR_OFS, 32'hFFFF_FFFF, 32'h00FF_FFFE, RESP_OKAY);
    rreg(CUR_ADDR_OFS, 32'hFFFF_FFFF, 32'h0100_0001, RESP_OKAY);
    results();
  end
endmodule : flash_extended_addressing_tb

bind fxa_decoder fxa_decoder_chk #(.ARRAY_BYTES(ARRAY_BYTES)) chk (.clk, .sys_rst, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .cmd);

// file: test/fxa_decoder_chk.sv
/*
  Assertions on the decoder's command outputs and bus handshakes.
  Assumes a bind onto fxa_decoder with its array size passed on.
*/
`timescale 1ns/1ps
module fxa_decoder_chk #(
  parameter int ARRAY_BYTES = 32'h0200_0000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // Decoded command
  input wire fxa_pkg::fxa_cmd_s cmd
);
  import fxa_pkg::*;
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // Command strobes and addresses
  a_valid_pulse: assert property (cmd.valid |=> !cmd.valid)
    else $error("valid longer than one cycle");
  a_strobe_pulse: assert property (cmd.byteStrobe |=> !cmd.byteStrobe)
    else $error("byte strobe longer than one cycle");
  a_start_cur: assert property (cmd.valid |-> cmd.curAddr == cmd.startAddr)
    else $error("current address not at start");
  a_cur_step: assert property (cmd.byteStrobe |->
    cmd.curAddr == (($past(cmd.curAddr) >= ARRAY_BYTES - 1) ? 32'h0 : $past(cmd.curAddr) + 32'h1))
    else $error("current address did not step by one");
  a_narrow_bank: assert property (cmd.valid && !cmd.wide |-> cmd.startAddr[31:25] == 7'h00)
    else $error("narrow address has upper bits set");
  a_fixed_wide: assert property (cmd.valid && cmd.opcode inside {8'h13, 8'h0C, 8'h12, 8'h21, 8'hE3} |->
    cmd.wide)
    else $error("dedicated wide opcode taken narrow");

  // Bus answers and refusals
  a_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_write_resp: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |->
    ##[1:2] s_axi_bvalid)
    else $error("write response late");
  a_aw_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");

  // Main scenarios
  c_wide: cover property (cmd.valid && cmd.wide);
  c_narrow: cover property (cmd.valid && !cmd.wide);
  c_cross: cover property (cmd.byteStrobe && cmd.curAddr[23:0] == 24'h0);
endmodule : fxa_decoder_chk

// file: test/fxa_host.sv
/*
  Host controller model: drives chip enable, serial clock and data in frames.
  Assumes the caller starts a frame just after a clock edge of the bench.
*/
`timescale 1ns/1ps
module fxa_host (
  // Serial pins toward the device
  output logic spiCsN,
  output logic spiSck,
  output logic spiSi
);
  // Idle pins: deselected, clock parked low
  initial
  begin
    spiCsN = 1'b1;
    spiSck = 1'b0;
    spiSi = 1'b0;
  end

  // Opcode, address bytes, then random data bytes, 160 ns per bit
  task automatic frame(input logic [7:0] op, input logic [31:0] ad, input int na, input int nd);
    logic [7:0] b;
    #1.3 spiCsN = 1'b0;
    for (int i = 0; i < 1 + na + nd; i++)
    begin
      b = (i == 0) ? op : (i <= na) ? ad[8 * (na - i) +: 8] : 8'($urandom);
      for (int k = 7; k >= 0; k--)
      begin
        spiSi = b[k];
        #80 spiSck = 1'b1;
        #80 spiSck = 1'b0;
      end
    end
    #80 spiCsN = 1'b1;
    spiSi = ~spiSi;  // Released line shows no stale bit
    #400;
  endtask : frame
endmodule : fxa_host
